// *** common/gsm_regs.vh ***
`ifndef GSM_REGS_VH
`define GSM_REGS_VH
// ***************************************************
// register indices and reset values
// ***************************************************
`define GSM_IDX_RESIDUAL 9'h00C
`define GSM_IDX_MIXED_SOC_UNCOMPENSATED 9'h00D
`define GSM_IDX_AVAILABLE_SOC 9'h00E
`define GSM_IDX_AVAILABLE_CAPACITY 9'h01F
`define GSM_IDX_MIXED_CAPACITY_UNCOMPENSATED 9'h02B
`define GSM_IDX_STATUS 9'h03D
`define GSM_IDX_SOC_CHANGE_BETWEEN_RELAX 9'h046
`define GSM_IDX_VOLTAGE_GAUGE_REMAINING_CAP 9'h04A
`define GSM_IDX_QH 9'h04D
`define GSM_IDX_VOLTAGE_GAUGE_OCV 9'h0FB
`define GSM_IDX_VOLTAGE_GAUGE_SOC 9'h0FF
`define GSM_RST_SOC_CHANGE_BETWEEN_RELAX 16'h0190
`define GSM_RST_QH 16'h0000
// ***************************************************
// status field positions
// ***************************************************
`define GSM_BIT_DNR 0
`define GSM_BIT_LONG 6
`define GSM_BIT_FQ 7
`define GSM_BIT_EMPTY 8
`define GSM_BIT_RELAX 9
// ***************************************************
// device addresses and ranges
// ***************************************************
`define GSM_DEV_VOL 8'h6C
`define GSM_DEV_NV 8'h16
`define GSM_VOL_LO_END 8'h4F
`define GSM_VOL_HI_START 8'hB0
`define GSM_VOL_HI_END 8'hDF
`define GSM_NV_START 8'h80
`define GSM_SW_LO_END 16'h004F
`define GSM_SW_HI_START 16'h00B0
`define GSM_SW_HI_END 16'h00DF
`define GSM_SW_NV_START 16'h0180
`define GSM_SW_NV_END 16'h01FF
// ***************************************************
// lock select bits
// ***************************************************
`define GSM_LK_LIFE 0
`define GSM_LK_GAUGE 1
`define GSM_LK_GNV 2
`define GSM_LK_CFG 3
`define GSM_LK_PROT 4
// ***************************************************
// timing
// ***************************************************
`define GSM_CLK_MHZ 125
`define GSM_DNR_MIN_MS 445
`define GSM_DNR_MAX_MS 1845
`define GSM_LONG_RELAX_MIN 48
`define GSM_DNR_MIN_CYC (`GSM_DNR_MIN_MS * 1000 * `GSM_CLK_MHZ)
`define GSM_LONG_CYC (`GSM_LONG_RELAX_MIN * 40'd60000000 * `GSM_CLK_MHZ)
`endif

// *** rtl/gsm_top.v ***
`timescale 1ns/1ns
`default_nettype none
`include "gsm_regs.vh"
module gsm_top #(
  parameter [31:0] DNR_MIN_CYC = `GSM_DNR_MIN_CYC,
  parameter [39:0] LONG_CYC = `GSM_LONG_CYC
) (
  input wire clock, // 125 MHz
  input wire rst, // async, high
  input wire cell_insert, // pulse: cell inserted
  input wire outputs_updated, // pulse: outputs refreshed
  input wire relax_detect, // level: cell fully relaxed
  input wire load_detect, // pulse: current over load
  input wire eoc_met, // pulse: all end-of-charge met
  input wire empty_reached, // pulse: empty point
  input wire volt_recovered, // pulse: above recovery level
  input wire alg_we, // algorithm write strobe
  input wire [8:0] alg_index, // algorithm write index
  input wire [15:0] alg_data, // algorithm write data
  input wire [4:0] lock_set, // pulse: set locks
  input wire host_req, // pulse: host access
  input wire host_we, // 1 write, 0 read
  input wire host_single, // 1 single-wire, 0 2-wire
  input wire [7:0] host_dev, // 2-wire device address
  input wire [15:0] host_addr, // register address
  input wire [15:0] host_wdata, // write data
  output reg host_ack, // pulse: access done
  output reg host_nack, // pulse: unmapped
  output reg host_refused, // pulse: write dropped
  output reg [15:0] host_rdata, // read data
  output reg [4:0] lock_state, // locks held
  output reg [15:0] status_out // status word
);

  // ***************************************************
  // functions
  // ***************************************************
  // returns {hit, index}
  function [9:0] decode;
    input single;
    input [7:0] dev;
    input [15:0] a;
    begin
      decode = 10'h000;
      if (single) begin
        if (a <= `GSM_SW_LO_END ||
            (a >= `GSM_SW_HI_START && a <= `GSM_SW_HI_END) ||
            (a >= `GSM_SW_NV_START && a <= `GSM_SW_NV_END))
          decode = {1'b1, a[8:0]};
      end else if (dev == `GSM_DEV_VOL) begin
        if (a[7:0] <= `GSM_VOL_LO_END ||
            (a[7:0] >= `GSM_VOL_HI_START && a[7:0] <= `GSM_VOL_HI_END))
          decode = {2'b10, a[7:0]};
      end else if (dev == `GSM_DEV_NV) begin
        if (a[7:0] >= `GSM_NV_START)
          decode = {2'b11, a[7:0]};
      end
    end
  endfunction

  // lock guarding a page, 0 when none
  function [4:0] page_lock;
    input [4:0] page;
    begin
      case (page)
        5'h01, 5'h02, 5'h03, 5'h04, 5'h0B, 5'h0D:
          page_lock = 5'h01 << `GSM_LK_GAUGE;
        5'h18, 5'h19: page_lock = 5'h01 << `GSM_LK_GNV;
        5'h1A, 5'h1B, 5'h1E: page_lock = 5'h01 << `GSM_LK_LIFE;
        5'h1C: page_lock = 5'h01 << `GSM_LK_CFG;
        5'h1D: page_lock = 5'h01 << `GSM_LK_PROT;
        default: page_lock = 5'h00;
      endcase
    end
  endfunction

  function is_ro;
    input [8:0] i;
    begin
      case (i)
        `GSM_IDX_RESIDUAL, `GSM_IDX_MIXED_SOC_UNCOMPENSATED, `GSM_IDX_AVAILABLE_SOC,
        `GSM_IDX_AVAILABLE_CAPACITY, `GSM_IDX_MIXED_CAPACITY_UNCOMPENSATED, `GSM_IDX_STATUS,
        `GSM_IDX_SOC_CHANGE_BETWEEN_RELAX, `GSM_IDX_VOLTAGE_GAUGE_REMAINING_CAP, `GSM_IDX_QH,
        `GSM_IDX_VOLTAGE_GAUGE_OCV, `GSM_IDX_VOLTAGE_GAUGE_SOC: is_ro = 1'b1;
        default: is_ro = 1'b0;
      endcase
    end
  endfunction

  // ***************************************************
  // storage
  // ***************************************************
  reg [15:0] mem [0:511];
  reg [15:0] soc_change_between_relax;
  reg [15:0] raw_qh;
  reg [15:0] mixed_capacity_uncompensated;
  reg [15:0] residual;
  reg [15:0] available_capacity;
  reg data_not_ready_flag;
  reg long_relax;
  reg fq;
  reg empty;
  reg relaxed;
  reg [31:0] dnr_cnt;
  reg [39:0] relax_cnt;

  wire [9:0] dec = decode(host_single, host_dev, host_addr);
  wire hit = dec[9];
  wire [8:0] idx = dec[8:0];
  wire locked = |(page_lock(idx[8:4]) & lock_state);
  wire ro = is_ro(idx);
  wire host_wr_ok = host_req && host_we && hit && !locked && !ro;
  wire [15:0] status_word;

  assign status_word = {6'h00, relaxed, empty, fq, long_relax,
                        5'h00, data_not_ready_flag};

  // ***************************************************
  // algorithm and host writes
  // ***************************************************
  always @(posedge clock) begin
    if (host_wr_ok)
      mem[idx] <= host_wdata;
    else if (alg_we)
      mem[alg_index] <= alg_data;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      soc_change_between_relax <= `GSM_RST_SOC_CHANGE_BETWEEN_RELAX;
      raw_qh <= `GSM_RST_QH;
      mixed_capacity_uncompensated <= 16'h0000;
      residual <= 16'h0000;
    end else if (alg_we) begin
      if (alg_index == `GSM_IDX_SOC_CHANGE_BETWEEN_RELAX)
        soc_change_between_relax <= alg_data;
      if (alg_index == `GSM_IDX_QH)
        raw_qh <= alg_data;
      if (alg_index == `GSM_IDX_MIXED_CAPACITY_UNCOMPENSATED)
        mixed_capacity_uncompensated <= alg_data;
      if (alg_index == `GSM_IDX_RESIDUAL)
        residual <= alg_data;
    end
  end

  // saturates at zero when residual exceeds mixed capacity
  always @(posedge clock or posedge rst) begin
    if (rst)
      available_capacity <= 16'h0000;
    else if (mixed_capacity_uncompensated > residual)
      available_capacity <= mixed_capacity_uncompensated - residual;
    else
      available_capacity <= 16'h0000;
  end

  // ***************************************************
  // locks
  // ***************************************************
  always @(posedge clock or posedge rst) begin
    if (rst)
      lock_state <= 5'h00;
    else
      lock_state <= lock_state | lock_set;
  end

  // ***************************************************
  // status flags
  // ***************************************************
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      data_not_ready_flag <= 1'b1;
      dnr_cnt <= 32'h00000000;
    end else if (cell_insert) begin
      data_not_ready_flag <= 1'b1;
      dnr_cnt <= 32'h00000000;
    end else if (data_not_ready_flag) begin
      if (dnr_cnt < DNR_MIN_CYC)
        dnr_cnt <= dnr_cnt + 32'h00000001;
      else if (outputs_updated)
        data_not_ready_flag <= 1'b0;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      relaxed <= 1'b0;
    else if (load_detect)
      relaxed <= 1'b0;
    else if (relax_detect)
      relaxed <= 1'b1;
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      long_relax <= 1'b0;
      relax_cnt <= 40'h0000000000;
    end else if (!relaxed) begin
      long_relax <= 1'b0;
      relax_cnt <= 40'h0000000000;
    end else if (relax_cnt >= LONG_CYC - 40'h0000000001) begin
      long_relax <= 1'b1;
    end else begin
      relax_cnt <= relax_cnt + 40'h0000000001;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      fq <= 1'b0;
    else if (eoc_met)
      fq <= 1'b1;
    else if (cell_insert)
      fq <= 1'b0;
  end

  always @(posedge clock or posedge rst) begin
    if (rst)
      empty <= 1'b0;
    else if (empty_reached)
      empty <= 1'b1;
    else if (volt_recovered)
      empty <= 1'b0;
  end

  // ***************************************************
  // host answers
  // ***************************************************
  reg [15:0] next_rdata;
  always @* begin
    case (idx)
      `GSM_IDX_STATUS: next_rdata = status_word;
      `GSM_IDX_AVAILABLE_CAPACITY: next_rdata = available_capacity;
      `GSM_IDX_SOC_CHANGE_BETWEEN_RELAX: next_rdata = soc_change_between_relax;
      `GSM_IDX_QH: next_rdata = raw_qh;
      default: next_rdata = mem[idx];
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      host_ack <= 1'b0;
      host_nack <= 1'b0;
      host_refused <= 1'b0;
      host_rdata <= 16'h0000;
      status_out <= 16'h0001;
    end else begin
      status_out <= status_word;
      host_ack <= host_req && hit;
      host_nack <= host_req && !hit;
      host_refused <= host_req && host_we && hit && (locked || ro);
      if (host_req && !host_we && hit)
        host_rdata <= next_rdata;
    end
  end

endmodule
`default_nettype wire

// *** tb/gsm_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module gsm_props (
  input wire clock, // clk
  input wire rst, // reset
  input wire cell_insert, // in
  input wire load_detect, // in
  input wire eoc_met, // in
  input wire empty_reached, // in
  input wire host_req, // in
  input wire host_we, // in
  input wire host_single, // in
  input wire [15:0] host_addr, // in
  input wire host_ack, // out
  input wire host_nack, // out
  input wire host_refused, // out
  input wire [4:0] lock_state, // out
  input wire [15:0] status_out // out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  ack_one_a: assert property (host_req |=> host_ack ^ host_nack)
    else $error("request without single answer");
  ack_idle_a: assert property (!host_req |=> !(host_ack | host_nack))
    else $error("answer without request");
  refuse_ack_a: assert property (host_refused |-> host_ack)
    else $error("refusal without ack");
  available_capacity_ro_a: assert property (host_req && host_we && host_single &&
    host_addr == 16'h001F |=> host_refused)
    else $error("read-only write not refused");
  status_pad_a: assert property ((status_out & 16'hFC3E) == 16'h0000)
    else $error("status padding set");
  dnr_set_a: assert property (cell_insert |-> ##2 status_out[0])
    else $error("not-ready not set");
  fq_set_a: assert property (eoc_met |-> ##2 status_out[7])
    else $error("full flag not set");
  empty_set_a: assert property (empty_reached |-> ##2 status_out[8])
    else $error("empty flag not set");
  relax_clr_a: assert property (load_detect |-> ##2 !status_out[9])
    else $error("relaxed flag not cleared");
  lock_keep_a: assert property ((lock_state & $past(lock_state)) ==
    $past(lock_state))
    else $error("lock released");
  long_clr_a: assert property ($fell(status_out[9]) |=> !status_out[6])
    else $error("long relax kept");
endmodule
bind gsm_top gsm_props i_gsm_props (.clock, .rst, .cell_insert, .load_detect,
  .eoc_met, .empty_reached, .host_req, .host_we, .host_single, .host_addr,
  .host_ack, .host_nack, .host_refused, .lock_state, .status_out);
`default_nettype wire

// *** tb/gsm_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module gsm_host_model (
  input wire clock, // clk
  output reg host_req = 1'b0, // request
  output reg host_we = 1'b0, // write
  output reg host_single = 1'b0, // bus select
  output reg [7:0] host_dev = 8'h00, // device address
  output reg [15:0] host_addr = 16'h0000, // register address
  output reg [15:0] host_wdata = 16'h0000, // write data
  input wire host_ack, // done
  input wire host_nack, // unmapped
  input wire host_refused, // dropped
  input wire [15:0] host_rdata // read data
);
  task acc(input w, input s, input [7:0] d, input [15:0] a,
    input [15:0] wd, output [2:0] r, output [15:0] q);
    begin
      @(posedge clock);
      host_req <= 1'b1;
      host_we <= w;
      host_single <= s;
      host_dev <= d;
      host_addr <= s ? a : {8'h00, a[7:0]};
      host_wdata <= wd;
      @(posedge clock);
      host_req <= 1'b0;
      host_wdata <= ~wd;
      #1;
      r = {host_ack, host_nack, host_refused};
      q = host_rdata;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  reg clock = 1'b0, rst = 1'b1, alg_we = 1'b0;
  reg [6:0] evb = 7'h00;
  reg [8:0] alg_index = 9'h000;
  reg [15:0] alg_data = 16'h0000, st = 16'h0001, q, v, a;
  reg [4:0] lock_set = 5'h00, lkv = 5'h00;
  wire host_req, host_we, host_single, host_ack, host_nack, host_refused;
  wire [7:0] host_dev;
  wire [15:0] host_addr, host_wdata, host_rdata, status_out;
  wire [4:0] lock_state;
  integer n_errors = 0, n_compared = 0, i, mem[0:511];
  reg [511:0] wr = 0;
  reg [2:0] r;
  reg sw;
  reg [7:0] dv;
  always #4 clock = ~clock;
  gsm_top #(.DNR_MIN_CYC(32'd20), .LONG_CYC(40'd50)) i_gsm_top (.clock, .rst,
    .cell_insert(evb[6]), .outputs_updated(evb[5]), .relax_detect(evb[4]),
    .load_detect(evb[3]), .eoc_met(evb[2]), .empty_reached(evb[1]),
    .volt_recovered(evb[0]), .alg_we, .alg_index, .alg_data, .lock_set,
    .host_req, .host_we, .host_single, .host_dev, .host_addr, .host_wdata,
    .host_ack, .host_nack, .host_refused, .host_rdata, .lock_state,
    .status_out);
  gsm_host_model i_gsm_host_model (.clock, .host_req, .host_we, .host_single,
    .host_dev, .host_addr, .host_wdata, .host_ack, .host_nack, .host_refused,
    .host_rdata);
  task end_of_test;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string n, input [15:0] s, input [15:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
    end
  endtask
  function integer ix(input s, input [7:0] d, input [15:0] a);
    if (s)
      ix = (a <= 16'h004F || (a >= 16'h00B0 && a <= 16'h00DF) ||
        (a >= 16'h0180 && a <= 16'h01FF)) ? a[8:0] : -1;
    else if (d == 8'h6C && (a[7:0] <= 8'h4F || (a[7:0] >= 8'hB0 &&
      a[7:0] <= 8'hDF)))
      ix = a[7:0];
    else if (d == 8'h16 && a[7:0] >= 8'h80)
      ix = 256 + a[7:0];
    else
      ix = -1;
  endfunction
  function integer lk(input integer j);
    case (j / 16)
      1, 2, 3, 4, 11, 13: lk = 1;
      24, 25: lk = 2;
      26, 27, 30: lk = 0;
      28: lk = 3;
      29: lk = 4;
      default: lk = -1;
    endcase
  endfunction
  function ro(input integer j);
    ro = j == 12 || j == 13 || j == 14 || j == 31 || j == 43 || j == 61 ||
      j == 70 || j == 74 || j == 77 || j == 251 || j == 255;
  endfunction
  task hacc(input w, input s, input [7:0] d, input [15:0] a);
    integer x, k;
    begin
      x = ix(s, d, a);
      v = $urandom;
      i_gsm_host_model.acc(w, s, d, a, v, r, q);
      k = x >= 0 && w && (ro(x) || (lk(x) >= 0 && lkv[lk(x)]));
      chk("answer", {13'h0, r}, x < 0 ? 16'h0002 : k ? 16'h0005 : 16'h0004);
      if (x >= 0 && w && !k) begin
        mem[x] = v;
        wr[x] = 1'b1;
      end
      if (x >= 0 && !w && wr[x])
        chk("rdata", q, mem[x][15:0]);
    end
  endtask
  task aw(input [8:0] j, input [15:0] d);
    begin
      @(posedge clock);
      alg_we <= 1'b1;
      alg_index <= j;
      alg_data <= d;
      @(posedge clock);
      alg_we <= 1'b0;
    end
  endtask
  task ev(input [6:0] p);
    begin
      @(posedge clock) evb <= p;
      @(posedge clock) evb <= 7'h00;
      repeat (2) @(posedge clock);
      #1;
      chk("status", status_out, st);
      mem[61] = st;
      wr[61] = 1'b1;
      hacc(1'b0, 1'b1, 8'h00, 16'h003D);
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    end_of_test;
  end
  initial begin
    i = $urandom(32'hd465);
    mem[70] = 16'h0190;
    mem[77] = 0;
    mem[31] = 0;
    wr[70] = 1'b1;
    wr[77] = 1'b1;
    wr[31] = 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    #1;
    chk("status", status_out, st);
    chk("locks", {11'h0, lock_state}, 16'h0000);
    hacc(1'b0, 1'b0, 8'h6C, 16'h0046);
    hacc(1'b0, 1'b0, 8'h6C, 16'h004D);
    aw(9'h02B, 16'h03E8);
    aw(9'h00C, 16'h012C);
    mem[31] = 16'h02BC;
    hacc(1'b0, 1'b0, 8'h6C, 16'h001F);
    aw(9'h00C, 16'h04B0);
    mem[31] = 0;
    hacc(1'b0, 1'b1, 8'h00, 16'h001F);
    for (i = 0; i < 256; i = i + 1)
      if (ro(i) && i != 61) begin
        hacc(1'b1, 1'b1, 8'h00, i[15:0]);
        hacc(1'b0, 1'b1, 8'h00, i[15:0]);
      end
    for (i = 0; i < 60; i = i + 1) begin
      a = $urandom % 576;
      if (a[7:0] == 8'h3D)
        a = a + 16'h0001;
      v = $urandom % 4;
      dv = v == 0 ? 8'h16 : v == 1 ? 8'h55 : 8'h6C;
      sw = $urandom;
      if (ix(sw, dv, a) >= 0)
        hacc(1'b1, sw, dv, a);
      hacc(1'b0, sw, dv, a);
    end
    ev(7'h40);
    ev(7'h20);
    repeat (20) @(posedge clock);
    st = 16'h0000;
    ev(7'h20);
    st = 16'h0080;
    ev(7'h04);
    st = 16'h0180;
    ev(7'h02);
    st = 16'h0080;
    ev(7'h01);
    st = 16'h0280;
    ev(7'h10);
    repeat (60) @(posedge clock);
    st = 16'h02C0;
    ev(7'h00);
    st = 16'h0080;
    ev(7'h08);
    st = 16'h0001;
    ev(7'h40);
    for (i = 0; i < 5; i = i + 1) begin
      a = (i == 0 ? 26 : i == 1 ? 1 : i == 2 ? 24 : i == 3 ? 28 : 29) * 16 + 5;
      hacc(1'b1, 1'b1, 8'h00, a);
      @(posedge clock) lock_set <= 5'h01 << i;
      @(posedge clock) lock_set <= 5'h00;
      lkv[i] = 1'b1;
      hacc(1'b1, 1'b1, 8'h00, a);
      hacc(1'b0, 1'b1, 8'h00, a);
      chk("locks", {11'h0, lock_state}, {11'h0, lkv});
    end
    end_of_test;
  end
endmodule
`default_nettype wire
